/* rtl/pcds_pkg.sv */
package pcds_pkg;
  localparam int unsigned NUM_POST          = 3;
  localparam int unsigned RATIO_W           = 5;
  localparam int unsigned MULT_W            = 5;
  localparam int unsigned CLK_SYS_MHZ       = 25;
  // Reset values of control state
  localparam logic             PATH_SEL_RST  = 1'b0;
  localparam logic             CORE_RST_RST  = 1'b1;
  localparam logic             SLEEP_RST     = 1'b0;
  localparam logic [MULT_W-1:0] MULT_RST     = 5'h04;
  localparam logic [RATIO_W-1:0] PREDIV_RST  = 5'h00;
  localparam logic [NUM_POST*RATIO_W-1:0] POST_RATIO_RST = {5'h02, 5'h01, 5'h00};
  localparam logic [NUM_POST-1:0] POST_ON_RST = 3'h7;
  // Valid multiplier code range
  localparam logic [MULT_W-1:0] MULT_MIN     = 5'h04;
  localparam logic [MULT_W-1:0] MULT_MAX     = 5'h19;

  typedef enum logic [1:0] {
    PCDS_IDLE  = 2'b00,
    PCDS_PAUSE = 2'b01,
    PCDS_LOAD  = 2'b10
  } pcds_upd_e;
endpackage

/* rtl/pcds_divider.sv */
`timescale 1ns/10ps
module pcds_divider (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          srst,
  // Source and control
  input  wire logic                          src_en,
  input  wire logic                          divider_on,
  input  wire logic                          hold_low,
  input  wire logic                          restart,
  input  wire logic [pcds_pkg::RATIO_W-1:0]  ratio,
  // Clock output
  output logic                               clk_out
);
  import pcds_pkg::*;

  typedef struct packed {
    logic [RATIO_W:0] cnt;
    logic             out;
  } pcds_div_s;

  pcds_div_s st_q;
  pcds_div_s st_d;
  logic [RATIO_W:0] div_n;
  logic [RATIO_W:0] half_n;

  // Divide by 2*(ratio+1): toggle every ratio+1 source ticks, 50% duty
  assign div_n   = {1'b0, ratio} + {{RATIO_W{1'b0}}, 1'b1};
  assign half_n  = div_n;
  assign clk_out = st_q.out;

  always_comb begin
    st_d = st_q;
    if (!divider_on || hold_low) begin
      st_d.cnt = '0;
      st_d.out = 1'b0;
    end else if (restart) begin
      st_d.cnt = '0;
      st_d.out = 1'b1;
    end else if (src_en) begin
      if (st_d.cnt + 1'b1 >= half_n) begin
        st_d.cnt = '0;
        st_d.out = ~st_q.out;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule // pcds_divider

/* rtl/pcds_sequencer.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - New ratios wait for an update operation.
// - Trigger write of 1 starts update.
// - Aligned clocks held low, restart together.
// - Unaligned clocks keep running old ratio.
// - Busy flag high during whole update.
// - Reset gives bypass and core reset.
// - Sleep bit powers PLL down.
// - Osc sleep bit powers oscillator down.
// - Only chip reset leaves oscillator sleep.
// - Path select chooses PLL or bypass.
// - Multiplier codes 4h-19h give x4-x25.
// - Dividers 1..32, silent when off; the code divides source ticks by 2*(ratio+1), so 2..64.
// - Post-divider outputs have 50% duty.
module pcds_sequencer (
  // Clock and reset
  input  wire logic                                    clk_sys,
  input  wire logic                                    srst,
  // Reference and multiplied clock qualifiers
  input  wire logic                                    ref_tick,
  input  wire logic                                    multiplied_clock,
  // Path and power controls
  input  wire logic                                    pll_path_select_wr,
  input  wire logic                                    pll_path_select_in,
  input  wire logic                                    pll_core_reset_wr,
  input  wire logic                                    pll_core_reset_in,
  input  wire logic                                    pll_sleep_wr,
  input  wire logic                                    pll_sleep_in,
  input  wire logic                                    osc_sleep_wr,
  // Ratio programming
  input  wire logic                                    prediv_wr,
  input  wire logic [pcds_pkg::RATIO_W-1:0]            prediv_in,
  input  wire logic                                    multiplier_wr,
  input  wire logic [pcds_pkg::MULT_W-1:0]             multiplier_in,
  input  wire logic [pcds_pkg::NUM_POST-1:0]           postdiv_wr,
  input  wire logic [pcds_pkg::NUM_POST*pcds_pkg::RATIO_W-1:0] postdiv_ratio_in,
  input  wire logic [pcds_pkg::NUM_POST-1:0]           divider_on_in,
  input  wire logic [pcds_pkg::NUM_POST-1:0]           align_select,
  input  wire logic                                    update_trigger,
  // Status and control outputs
  output logic                                         pll_path_select,
  output logic                                         pll_core_reset,
  output logic                                         pll_sleep,
  output logic                                         osc_sleep,
  output logic [pcds_pkg::RATIO_W-1:0]                 prediv,
  output logic [pcds_pkg::MULT_W-1:0]                  multiplier_field,
  output logic                                         multiplier_valid,
  output logic                                         update_in_progress,
  output logic [pcds_pkg::NUM_POST-1:0]                system_clock_out
);
  import pcds_pkg::*;

  // Whole sequencer state, registered in one place
  typedef struct packed {
    logic                          path;
    logic                          core_rst;
    logic                          sleep;
    logic                          osc;
    logic [RATIO_W-1:0]            prediv;
    logic [MULT_W-1:0]             mult;
    logic [NUM_POST*RATIO_W-1:0]   prog_ratio;
    logic [NUM_POST*RATIO_W-1:0]   act_ratio;
    logic [NUM_POST-1:0]           on;
    logic [NUM_POST-1:0]           align;
    logic [NUM_POST-1:0]           hold;
    logic [NUM_POST-1:0]           restart;
    pcds_upd_e                     upd;
    logic [1:0]                    ref_s;
    logic [1:0]                    mul_s;
    logic                          mul_prev;
  } pcds_seq_s;

  pcds_seq_s st_q;
  pcds_seq_s st_d;
  logic      mul_edge;
  logic      src_en;

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic mult_ok(input logic [MULT_W-1:0] code);
    mult_ok = (code >= MULT_MIN) && (code <= MULT_MAX);
  endfunction

  // -------------------------------------------------------------
  // Source tick selection
  // -------------------------------------------------------------
  // Rising edge of the synchronised multiplied clock
  assign mul_edge = st_q.mul_s[1] & ~st_q.mul_prev;
  // Bypass counts reference samples, PLL mode counts multiplied edges
  assign src_en   = st_q.path ? mul_edge : st_q.ref_s[1];

  // -------------------------------------------------------------
  // Control and update sequencing
  // -------------------------------------------------------------
  always_comb begin
    st_d          = st_q;
    // Two-stage synchronisers on the asynchronous qualifiers
    st_d.ref_s    = {st_q.ref_s[0], ref_tick};
    st_d.mul_s    = {st_q.mul_s[0], multiplied_clock};
    st_d.mul_prev = st_q.mul_s[1];
    st_d.restart  = '0;
    // Software write strobes
    if (pll_path_select_wr) begin
      st_d.path = pll_path_select_in;
    end
    if (pll_core_reset_wr) begin
      st_d.core_rst = pll_core_reset_in;
    end
    if (pll_sleep_wr) begin
      st_d.sleep = pll_sleep_in;
    end
    if (osc_sleep_wr) begin
      st_d.osc = 1'b1;
    end
    if (prediv_wr) begin
      st_d.prediv = prediv_in;
    end
    if (multiplier_wr) begin
      st_d.mult = multiplier_in;
    end
    // Enables follow their level inputs
    st_d.on = divider_on_in;
    for (int i = 0; i < NUM_POST; i++) begin
      if (postdiv_wr[i]) begin
        st_d.prog_ratio[i*RATIO_W +: RATIO_W] = postdiv_ratio_in[i*RATIO_W +: RATIO_W];
      end
    end
    // Ratio-update operation: hold, reload and restart
    case (st_q.upd)
      PCDS_IDLE: begin
        if (update_trigger) begin
          st_d.align = align_select;
          // Aligned clocks go low from the edge after next, once hold is registered
          st_d.hold  = align_select;
          st_d.upd   = PCDS_PAUSE;
        end
      end
      PCDS_PAUSE: begin
        // Aligned clocks sit low while the new ratios load
        for (int i = 0; i < NUM_POST; i++) begin
          if (st_q.align[i]) begin
            st_d.act_ratio[i*RATIO_W +: RATIO_W] = st_q.prog_ratio[i*RATIO_W +: RATIO_W];
          end
        end
        st_d.hold    = '0;
        st_d.restart = st_q.align;
        st_d.upd     = PCDS_LOAD;
      end
      PCDS_LOAD: begin
        // Common restart edge shows now, busy falls with it
        st_d.upd = PCDS_IDLE;
      end
      default: begin
        st_d.upd = PCDS_IDLE;
      end
    endcase
  end

  // -------------------------------------------------------------
  // State register
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q            <= '0;
      // Leave reset in bypass with the PLL core held in reset
      st_q.path       <= PATH_SEL_RST;
      st_q.core_rst   <= CORE_RST_RST;
      st_q.sleep      <= SLEEP_RST;
      st_q.prediv     <= PREDIV_RST;
      st_q.mult       <= MULT_RST;
      st_q.prog_ratio <= POST_RATIO_RST;
      st_q.act_ratio  <= POST_RATIO_RST;
      st_q.on         <= POST_ON_RST;
      st_q.upd        <= PCDS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // -------------------------------------------------------------
  // Post dividers
  // -------------------------------------------------------------
  genvar g;
  generate
    // One divider per system clock, all fed by the same source tick
    for (g = 0; g < NUM_POST; g++) begin : g_post
      pcds_divider u_div (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .src_en   (src_en),
        .divider_on (st_q.on[g]),
        .hold_low (st_q.hold[g]),
        .restart  (st_q.restart[g]),
        .ratio    (st_q.act_ratio[g*RATIO_W +: RATIO_W]),
        .clk_out  (system_clock_out[g])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // Status and control outputs
  // -------------------------------------------------------------
  assign pll_path_select    = st_q.path;
  assign pll_core_reset     = st_q.core_rst;
  assign pll_sleep          = st_q.sleep;
  assign osc_sleep          = st_q.osc;
  assign prediv             = st_q.prediv;
  assign multiplier_field   = st_q.mult;
  assign multiplier_valid   = mult_ok(st_q.mult);
  assign update_in_progress = (st_q.upd != PCDS_IDLE);
endmodule // pcds_sequencer

/* verification/pcds_seq_properties.sv */
`timescale 1ns/10ps
module pcds_seq_props (
  // Watched ports
  input wire logic                          clk_sys,
  input wire logic                          srst,
  input wire logic                          update_trigger,
  input wire logic                          pll_path_select_wr,
  input wire logic                          pll_path_select_in,
  input wire logic                          pll_sleep_wr,
  input wire logic                          pll_sleep_in,
  input wire logic                          osc_sleep_wr,
  input wire logic [pcds_pkg::NUM_POST-1:0] align_select,
  input wire logic [pcds_pkg::NUM_POST-1:0] divider_on_in,
  input wire logic                          pll_path_select,
  input wire logic                          pll_sleep,
  input wire logic                          osc_sleep,
  input wire logic [pcds_pkg::MULT_W-1:0]   multiplier_field,
  input wire logic                          multiplier_valid,
  input wire logic                          update_in_progress,
  input wire logic [pcds_pkg::NUM_POST-1:0] system_clock_out
);
  import pcds_pkg::*;
  // ----------------------------------------
  // Update sequence, control writes and divider enables
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence busy_s;
    update_in_progress [*2] ##1 !update_in_progress;
  endsequence
  sequence align_s;
    ((system_clock_out & align_select) == 3'h0) ##1 ((system_clock_out & align_select) == align_select);
  endsequence
  start_upd_a: assert property (update_trigger && !update_in_progress |=> busy_s)
    else $error("update busy window wrong");
  busy_len_a: assert property ($rose(update_in_progress) |=> update_in_progress ##1 !update_in_progress)
    else $error("busy flag length wrong");
  no_start_a: assert property (!update_trigger && !update_in_progress |=> !update_in_progress)
    else $error("update started unasked");
  align_rst_a: assert property ($rose(update_in_progress) |=> align_s)
    else $error("aligned clocks not restarted together");
  osc_keep_a: assert property (osc_sleep |=> osc_sleep)
    else $error("oscillator sleep cleared");
  osc_set_a: assert property (osc_sleep_wr |=> osc_sleep)
    else $error("oscillator sleep not set");
  path_wr_a: assert property (pll_path_select_wr |=> pll_path_select == $past(pll_path_select_in))
    else $error("path select not written");
  sleep_wr_a: assert property (pll_sleep_wr |=> pll_sleep == $past(pll_sleep_in))
    else $error("pll sleep not written");
  mult_ok_a: assert property (multiplier_valid == (multiplier_field >= MULT_MIN && multiplier_field <= MULT_MAX))
    else $error("multiplier valid flag wrong");
  off_quiet_a: assert property ((system_clock_out & ~$past(divider_on_in, 2)) == 3'h0)
    else $error("disabled divider still toggling");
endmodule // pcds_seq_props

bind pcds_sequencer pcds_seq_props u_props (
  .clk_sys            (clk_sys),
  .srst               (srst),
  .update_trigger     (update_trigger),
  .pll_path_select_wr (pll_path_select_wr),
  .pll_path_select_in (pll_path_select_in),
  .pll_sleep_wr       (pll_sleep_wr),
  .pll_sleep_in       (pll_sleep_in),
  .osc_sleep_wr       (osc_sleep_wr),
  .align_select       (align_select),
  .divider_on_in      (divider_on_in),
  .pll_path_select    (pll_path_select),
  .pll_sleep          (pll_sleep),
  .osc_sleep          (osc_sleep),
  .multiplier_field   (multiplier_field),
  .multiplier_valid   (multiplier_valid),
  .update_in_progress (update_in_progress),
  .system_clock_out   (system_clock_out)
);

/* verification/pll_clock_divider_sequencer_tb_top.sv */
`timescale 1ns/10ps
module pll_clock_divider_sequencer_tb_top;
  import pcds_pkg::*;
  logic clk_sys, srst, ref_tick, multiplied_clock, update_trigger, om;
  logic pll_path_select_wr, pll_path_select_in, pll_core_reset_wr, pll_core_reset_in;
  logic pll_sleep_wr, pll_sleep_in, osc_sleep_wr, prediv_wr, multiplier_wr;
  logic pll_path_select, pll_core_reset, pll_sleep, osc_sleep, multiplier_valid, update_in_progress;
  logic [4:0] prediv_in, multiplier_in, prediv, multiplier_field;
  logic [2:0] postdiv_wr, divider_on_in, align_select, system_clock_out;
  logic [14:0] postdiv_ratio_in;
  int fails, n_compared, p, pend[3], act[3];
  // ----------------------------------------
  // Harness and tasks
  // ----------------------------------------
  pcds_sequencer uut (
    .clk_sys(clk_sys), .srst(srst), .ref_tick(ref_tick), .multiplied_clock(multiplied_clock),
    .pll_path_select_wr(pll_path_select_wr), .pll_path_select_in(pll_path_select_in),
    .pll_core_reset_wr(pll_core_reset_wr), .pll_core_reset_in(pll_core_reset_in),
    .pll_sleep_wr(pll_sleep_wr), .pll_sleep_in(pll_sleep_in), .osc_sleep_wr(osc_sleep_wr),
    .prediv_wr(prediv_wr), .prediv_in(prediv_in), .multiplier_wr(multiplier_wr), .multiplier_in(multiplier_in),
    .postdiv_wr(postdiv_wr), .postdiv_ratio_in(postdiv_ratio_in), .divider_on_in(divider_on_in),
    .align_select(align_select), .update_trigger(update_trigger), .pll_path_select(pll_path_select),
    .pll_core_reset(pll_core_reset), .pll_sleep(pll_sleep), .osc_sleep(osc_sleep), .prediv(prediv),
    .multiplier_field(multiplier_field), .multiplier_valid(multiplier_valid),
    .update_in_progress(update_in_progress), .system_clock_out(system_clock_out)
  );
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) multiplied_clock <= ~multiplied_clock;
  task automatic cmp(logic [23:0] g, logic [23:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bail;
    fails++;
    final_report;
  endtask
  // Cycles between two rising edges of output i
  task automatic per(int i);
    bit f;
    logic o;
    f = 0;
    o = 1'b1;
    p = 0;
    for (int k = 0; k < 300; k++) begin
      @(negedge clk_sys);
      p += f;
      if (system_clock_out[i] === 1'b1 && o === 1'b0) begin
        if (f) return;
        f = 1;
      end
      o = system_clock_out[i];
    end
    bail;
  endtask
  // s: clock cycles per source tick
  task automatic chk_all(int s);
    for (int i = 0; i < 3; i++) begin
      per(i);
      cmp(p, s * 2 * (act[i] + 1));
    end
  endtask
  task automatic wr_ratio(int i, int r);
    @(posedge clk_sys);
    postdiv_wr <= 3'(1 << i);
    postdiv_ratio_in[5*i +: 5] <= 5'(r);
    @(posedge clk_sys);
    postdiv_wr <= 3'h0;
    pend[i] = r;
  endtask
  // Second trigger lands while busy and must be ignored
  task automatic go(logic [2:0] a);
    @(negedge clk_sys);
    cmp(update_in_progress, 0);
    @(posedge clk_sys);
    align_select <= a;
    update_trigger <= 1'b1;
    repeat (2) @(posedge clk_sys);
    update_trigger <= 1'b0;
    @(negedge clk_sys);
    cmp(update_in_progress, 1);
    for (int i = 0; i < 3; i++) begin
      if (a[i]) act[i] = pend[i];
    end
    for (int k = 0; k < 9 && update_in_progress !== 1'b0; k++) @(negedge clk_sys);
    if (update_in_progress !== 1'b0) bail;
  endtask
  // v = path, pll sleep, core reset, osc sleep
  task automatic ctl(logic [3:0] v);
    @(posedge clk_sys);
    {pll_path_select_wr, pll_sleep_wr, pll_core_reset_wr} <= 3'h7;
    {pll_path_select_in, pll_sleep_in, pll_core_reset_in, osc_sleep_wr} <= v;
    @(posedge clk_sys);
    {pll_path_select_wr, pll_sleep_wr, pll_core_reset_wr, osc_sleep_wr} <= 4'h0;
    om = om | v[0];
    @(negedge clk_sys);
    cmp({pll_path_select, pll_sleep, pll_core_reset, osc_sleep}, {v[3:1], om});
  endtask
  initial begin
    {clk_sys, ref_tick, multiplied_clock, update_trigger, om} = 5'h08;
    {pll_path_select_wr, pll_path_select_in, pll_core_reset_wr, pll_core_reset_in, pll_sleep_wr} = 5'h00;
    {pll_sleep_in, osc_sleep_wr, prediv_wr, multiplier_wr, prediv_in, multiplier_in} = 14'h0000;
    {postdiv_wr, postdiv_ratio_in, divider_on_in, align_select} = 24'h00003F;
    srst = 1'b1;
    pend = '{0, 1, 2};
    act = pend;
    void'($urandom(26));
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp({pll_path_select, pll_core_reset, multiplier_field, system_clock_out}, {2'h1, MULT_RST, 3'h0});
    @(posedge clk_sys);
    srst <= 1'b0;
    chk_all(1);
    for (int t = 0; t < 3; t++) begin
      for (int i = 0; i < 3; i++) begin
        wr_ratio(i, (t == 1 && i == 0) ? 31 : $urandom_range(7));
      end
      chk_all(1);
      go(t == 0 ? 3'h7 : 3'($urandom_range(7)));
      chk_all(1);
    end
    @(posedge clk_sys);
    divider_on_in <= 3'h5;
    repeat (70) @(posedge clk_sys);
    repeat (30) begin
      @(negedge clk_sys);
      cmp(system_clock_out[1], 0);
    end
    @(posedge clk_sys);
    divider_on_in <= 3'h7;
    go(3'h7);
    chk_all(1);
    ctl(4'h2);
    repeat (8) @(posedge clk_sys);
    for (int m = 0; m < 32; m++) begin
      @(posedge clk_sys);
      {multiplier_wr, prediv_wr, multiplier_in, prediv_in} <= {2'h3, 5'(m), 5'(31 - m)};
      @(posedge clk_sys);
      {multiplier_wr, prediv_wr} <= 2'h0;
      @(negedge clk_sys);
      cmp({multiplier_valid, multiplier_field, prediv}, {m >= 4 && m <= 25, 5'(m), 5'(31 - m)});
    end
    go(3'h7);
    ctl(4'h0);
    repeat (20) @(posedge clk_sys);
    ctl(4'h8);
    chk_all(2);
    ctl(4'h0);
    repeat (8) @(posedge clk_sys);
    ctl(4'h4);
    ctl(4'h5);
    ctl(4'h2);
    ctl(4'h0);
    repeat (20) @(posedge clk_sys);
    ctl(4'h8);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp({pll_path_select, pll_core_reset, pll_sleep, osc_sleep, system_clock_out}, {4'h4, 3'h0});
    final_report;
  end
endmodule // pll_clock_divider_sequencer_tb_top
